// ===== include/pmc_map.svh
// Register map, field positions, reset values and timing counts for the
// power mode controller. Definitions only; included by bare name.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_OFS_CTRL_A 16'hfff0
`define PMC_OFS_CTRL_B 16'hfff1

// power_mode_ctrl_a fields
`define PMC_A_DEEP_POWER 7
`define PMC_A_SETTLE_HI 6
`define PMC_A_SETTLE_LO 4
`define PMC_A_SLOW_CLOCK 3
`define PMC_A_MID_DIV_HI 1
`define PMC_A_MID_DIV_LO 0
`define PMC_A_RESET 8'h07

// power_mode_ctrl_b fields
`define PMC_B_SAMPLE_RATE 4
`define PMC_B_DIRECT_SWITCH 3
`define PMC_B_MID_SPEED 2
`define PMC_B_SUB_DIV_HI 1
`define PMC_B_SUB_DIV_LO 0
`define PMC_B_RESET 8'he0

// Oscillator settling waits, in states
`define PMC_SETTLE_0 8192
`define PMC_SETTLE_1 16384
`define PMC_SETTLE_2 32768
`define PMC_SETTLE_3 65536
`define PMC_SETTLE_4 131072
`define PMC_SETTLE_W 17

`endif

// ===== include/pmc_pkg.sv
// Types shared by the power mode controller and its clock divider.
// Assumes nothing beyond a SystemVerilog compiler.
package pmc_pkg;

    typedef enum logic [3:0] {
        PMC_ACT_HI,
        PMC_ACT_MID,
        PMC_SLEEP_HI,
        PMC_SLEEP_MID,
        PMC_SUBACT,
        PMC_SUBSLEEP,
        PMC_WATCH,
        PMC_STANDBY,
        PMC_SETTLE
    } pmc_mode_t;

    typedef logic [1:0] pmc_div_t;

endpackage

// ===== include/pmc_clk_if.sv
// Divider settings and rate enables between controller and clock divider.
// Assumes both ends run on the same oscillator clock.
`timescale 1ns/10ps
`default_nettype none

interface pmc_clk_if;
    pmc_pkg::pmc_div_t midDiv;
    logic sampleFast;
    pmc_pkg::pmc_div_t subDiv;
    logic watchClk;
    logic midTick;
    logic sampleTick;
    logic subTick;

    modport ctl (
        output midDiv,
        output sampleFast,
        output subDiv,
        output watchClk,
        input midTick,
        input sampleTick,
        input subTick
    );

    modport div (
        input midDiv,
        input sampleFast,
        input subDiv,
        input watchClk,
        output midTick,
        output sampleTick,
        output subTick
    );
endinterface

`default_nettype wire

// ===== hw/pmc_clk_div.sv
// Rate enables: medium-speed tick, watch-clock sample tick and
// subactive CPU tick. Assumes the watch clock is a level synchronous
// to core_clk.
`timescale 1ns/10ps
`default_nettype none

`include "pmc_map.svh"

module pmc_clk_div (
    input wire logic core_clk,
    input wire logic resetn,
    pmc_clk_if.div bus
);

    logic [6:0] oscCnt;
    logic watchSamp;
    logic watchPrev;
    logic [2:0] subCnt;
    wire watchRise;
    wire [2:0] subLast;
    wire midHit;
    wire sampleHit;

    // =====================================================
    // Decode
    // =====================================================
    // Divide by 16, 32, 64, 128 from one free-running counter
    assign midHit = (bus.midDiv == 2'h0) ? (oscCnt[3:0] == 4'hf) :
                    (bus.midDiv == 2'h1) ? (oscCnt[4:0] == 5'h1f) :
                    (bus.midDiv == 2'h2) ? (oscCnt[5:0] == 6'h3f) :
                    (oscCnt == 7'h7f);
    assign sampleHit = bus.sampleFast ? (oscCnt[1:0] == 2'h3)
                                      : (oscCnt[3:0] == 4'hf);
    assign watchRise = watchSamp & ~watchPrev;
    // Watch clock divided by 8, 4 or 2
    assign subLast = (bus.subDiv == 2'h0) ? 3'h7 :
                     (bus.subDiv == 2'h1) ? 3'h3 : 3'h1;

    // =====================================================
    // Counters
    // =====================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            oscCnt <= 7'h00;
        end else begin
            oscCnt <= oscCnt + 7'h01;
        end
    end

    // Sampling at a slow rate filters glitches on the watch clock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            watchSamp <= 1'b0;
            watchPrev <= 1'b0;
        end else if (sampleHit) begin
            watchSamp <= bus.watchClk;
            watchPrev <= watchSamp;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            subCnt <= 3'h0;
            bus.subTick <= 1'b0;
        end else begin
            bus.subTick <= 1'b0;
            if (sampleHit && watchRise) begin
                if (subCnt >= subLast) begin
                    subCnt <= 3'h0;
                    bus.subTick <= 1'b1;
                end else begin
                    subCnt <= subCnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus.midTick <= 1'b0;
            bus.sampleTick <= 1'b0;
        end else begin
            bus.midTick <= midHit;
            bus.sampleTick <= sampleHit;
        end
    end

endmodule // pmc_clk_div

`default_nettype wire

// ===== hw/pmc_power_mode_control.sv
// Power mode controller: two control registers and the mode sequencer
// that acts on the CPU's sleep instruction and on wake-up interrupts.
// Assumes core_clk is the oscillator clock, one state per cycle, and
// that the CPU pulses sleepExec for one cycle per sleep instruction.
//
// Contract
// - Deep select 0: sleep from active gives sleep, from subactive subsleep.
// - Deep select 1: active goes standby or watch; subactive goes watch.
// - From active with deep select, time-base bit picks watch else standby.
// - Wake to active waits 8192..131072 states by the 3-bit settle code.
// - Slow clock select picks subclock or system clock after watch.
// - Bit 2 of control A reads 1 and ignores writes.
// - Medium divider gives osc /16, /32, /64, /128; reset is /128.
// - Bits 7..5 of control B read 1 and ignore writes.
// - Sample select: 0 samples watch clock at osc/16, 1 at osc/4.
// - Direct switch 0: sleep enters standby, watch, sleep or subsleep.
// - Direct from high-speed goes to medium or subactive by bits.
// - Direct from medium-speed goes to high-speed or subactive by bits.
// - Direct from subactive goes to high or medium speed by mid bit.
// - Mid-speed bit steers resumption and sleep speed.
// - Subactive divider gives watch clock /8, /4, /2; reset /8.
// - Subactive divider writes are ignored during subactive operation.
// - Reset loads 0x07 into control A and 0xe0 into control B.
// - In standby port registers hold while port outputs float.
// - In standby and watch external interrupts are ignored, flags kept.
// - Timer A runs in watch and sub modes only with time-base selected.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

`include "pmc_map.svh"

module pmc_power_mode_control #(
    parameter int SETTLE_0 = `PMC_SETTLE_0,
    parameter int SETTLE_1 = `PMC_SETTLE_1,
    parameter int SETTLE_2 = `PMC_SETTLE_2,
    parameter int SETTLE_3 = `PMC_SETTLE_3,
    parameter int SETTLE_4 = `PMC_SETTLE_4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic sleepExec,
    input wire logic timebaseWatchSelect,
    input wire logic wakeTimerA,
    input wire logic wakeIrq0,
    input wire logic wakeIrq1,
    input wire logic wakeOther,
    input wire logic watchClk,
    output logic [3:0] modeCode,
    output logic cpuRun,
    output logic cpuClkEn,
    output logic sysOscRun,
    output logic portHiZ,
    output logic extIrqHold,
    output logic timerARun,
    output logic watchSampleEn
);

    // =====================================================
    // Control registers
    // =====================================================
    logic deepPowerSelect;
    logic [2:0] settleTimeSel;
    logic slowClockSelect;
    pmc_pkg::pmc_div_t midSpeedDiv;
    logic watchSampleRateSelect;
    logic directSwitchSelect;
    logic midSpeedSelect;
    pmc_pkg::pmc_div_t subClockDiv;

    pmc_pkg::pmc_mode_t mode;
    pmc_pkg::pmc_mode_t next_mode;
    logic [`PMC_SETTLE_W-1:0] settleCnt;
    logic [`PMC_SETTLE_W-1:0] settleLast;

    wire selA;
    wire selB;
    wire wrA;
    wire wrB;
    wire [7:0] ctrlA;
    wire [7:0] ctrlB;
    wire [7:0] next_rdData;
    wire inSubact;
    wire wakeAny;
    wire settleDone;

    pmc_clk_if clkBus ();

    // =====================================================
    // Register decode
    // =====================================================
    assign selA = (regAddr == `PMC_OFS_CTRL_A);
    assign selB = (regAddr == `PMC_OFS_CTRL_B);
    assign wrA = regWr & selA;
    assign wrB = regWr & selB;
    assign inSubact = (mode == pmc_pkg::PMC_SUBACT);

    // Fixed bits are built into the read value, not stored
    assign ctrlA = {deepPowerSelect, settleTimeSel, slowClockSelect,
                    1'b1, midSpeedDiv};
    assign ctrlB = {3'h7, watchSampleRateSelect, directSwitchSelect,
                    midSpeedSelect, subClockDiv};
    // Unmapped reads return zero
    assign next_rdData = !regRd ? 8'h00 :
                         selA ? ctrlA :
                         selB ? ctrlB : 8'h00;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            deepPowerSelect <= 1'(`PMC_A_RESET >> `PMC_A_DEEP_POWER);
            settleTimeSel <= 3'h0;
            slowClockSelect <= 1'b0;
            midSpeedDiv <= 2'h3;
        end else if (wrA) begin
            deepPowerSelect <= regWrData[`PMC_A_DEEP_POWER];
            settleTimeSel <= regWrData[`PMC_A_SETTLE_HI:`PMC_A_SETTLE_LO];
            slowClockSelect <= regWrData[`PMC_A_SLOW_CLOCK];
            midSpeedDiv <= regWrData[`PMC_A_MID_DIV_HI:`PMC_A_MID_DIV_LO];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            watchSampleRateSelect <= 1'b0;
            directSwitchSelect <= 1'b0;
            midSpeedSelect <= 1'b0;
            subClockDiv <= 2'h0;
        end else if (wrB) begin
            watchSampleRateSelect <= regWrData[`PMC_B_SAMPLE_RATE];
            directSwitchSelect <= regWrData[`PMC_B_DIRECT_SWITCH];
            midSpeedSelect <= regWrData[`PMC_B_MID_SPEED];
            // Changing the divider under a running subclock CPU is unsafe
            if (!inSubact) begin
                subClockDiv <= regWrData[`PMC_B_SUB_DIV_HI:
                                         `PMC_B_SUB_DIV_LO];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_rdData;
        end
    end

    // =====================================================
    // Clock divider
    // =====================================================
    assign clkBus.midDiv = midSpeedDiv;
    assign clkBus.sampleFast = watchSampleRateSelect;
    assign clkBus.subDiv = subClockDiv;
    assign clkBus.watchClk = watchClk;

    pmc_clk_div uDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .bus(clkBus.div)
    );

    // =====================================================
    // Settling wait
    // =====================================================
    function automatic logic [`PMC_SETTLE_W-1:0] settleCount(
        input logic [2:0] code
    );
        int states;
        case (code)
            3'h0: states = SETTLE_0;
            3'h1: states = SETTLE_1;
            3'h2: states = SETTLE_2;
            3'h3: states = SETTLE_3;
            default: states = SETTLE_4;
        endcase
        settleCount = `PMC_SETTLE_W'(states - 1);
    endfunction

    // Code is latched at wake so a late write cannot stretch the wait
    assign settleDone = (settleCnt == settleLast);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settleCnt <= '0;
            settleLast <= '0;
        end else if (mode == pmc_pkg::PMC_SETTLE) begin
            settleCnt <= settleCnt + `PMC_SETTLE_W'(1);
        end else begin
            settleCnt <= '0;
            settleLast <= settleCount(settleTimeSel);
        end
    end

    // =====================================================
    // Mode sequencer
    // =====================================================
    assign wakeAny = wakeTimerA | wakeIrq0 | wakeIrq1 | wakeOther;

    // Low-power entry from active when no direct switch applies
    function automatic pmc_pkg::pmc_mode_t activeSleepTarget(
        input logic deep,
        input logic timebase,
        input logic mid
    );
        if (deep) begin
            activeSleepTarget = timebase ? pmc_pkg::PMC_WATCH
                                         : pmc_pkg::PMC_STANDBY;
        end else begin
            activeSleepTarget = mid ? pmc_pkg::PMC_SLEEP_MID
                                    : pmc_pkg::PMC_SLEEP_HI;
        end
    endfunction

    always_comb begin
        next_mode = mode;
        case (mode)
            pmc_pkg::PMC_ACT_HI: begin
                if (sleepExec) begin
                    if (directSwitchSelect && !deepPowerSelect &&
                        midSpeedSelect && !slowClockSelect) begin
                        next_mode = pmc_pkg::PMC_ACT_MID;
                    end else if (directSwitchSelect && deepPowerSelect &&
                                 timebaseWatchSelect && slowClockSelect) begin
                        next_mode = pmc_pkg::PMC_SUBACT;
                    end else begin
                        next_mode = activeSleepTarget(deepPowerSelect,
                            timebaseWatchSelect, midSpeedSelect);
                    end
                end
            end
            pmc_pkg::PMC_ACT_MID: begin
                if (sleepExec) begin
                    if (directSwitchSelect && !deepPowerSelect &&
                        !midSpeedSelect && !slowClockSelect) begin
                        next_mode = pmc_pkg::PMC_ACT_HI;
                    end else if (directSwitchSelect && deepPowerSelect &&
                                 timebaseWatchSelect && slowClockSelect) begin
                        next_mode = pmc_pkg::PMC_SUBACT;
                    end else begin
                        next_mode = activeSleepTarget(deepPowerSelect,
                            timebaseWatchSelect, midSpeedSelect);
                    end
                end
            end
            pmc_pkg::PMC_SUBACT: begin
                if (sleepExec) begin
                    if (directSwitchSelect && deepPowerSelect &&
                        timebaseWatchSelect && !slowClockSelect) begin
                        next_mode = midSpeedSelect ? pmc_pkg::PMC_ACT_MID
                                                   : pmc_pkg::PMC_ACT_HI;
                    end else if (deepPowerSelect) begin
                        next_mode = pmc_pkg::PMC_WATCH;
                    end else begin
                        next_mode = pmc_pkg::PMC_SUBSLEEP;
                    end
                end
            end
            pmc_pkg::PMC_SLEEP_HI: begin
                if (wakeAny) begin
                    next_mode = pmc_pkg::PMC_ACT_HI;
                end
            end
            pmc_pkg::PMC_SLEEP_MID: begin
                if (wakeAny) begin
                    next_mode = pmc_pkg::PMC_ACT_MID;
                end
            end
            pmc_pkg::PMC_SUBSLEEP: begin
                if (wakeAny) begin
                    next_mode = pmc_pkg::PMC_SUBACT;
                end
            end
            pmc_pkg::PMC_STANDBY: begin
                if (wakeIrq0 || wakeIrq1) begin
                    next_mode = pmc_pkg::PMC_SETTLE;
                end
            end
            pmc_pkg::PMC_WATCH: begin
                if (wakeTimerA || wakeIrq0) begin
                    next_mode = slowClockSelect ? pmc_pkg::PMC_SUBACT
                                                : pmc_pkg::PMC_SETTLE;
                end
            end
            pmc_pkg::PMC_SETTLE: begin
                if (settleDone) begin
                    next_mode = midSpeedSelect ? pmc_pkg::PMC_ACT_MID
                                               : pmc_pkg::PMC_ACT_HI;
                end
            end
            default: next_mode = pmc_pkg::PMC_ACT_HI;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= pmc_pkg::PMC_ACT_HI;
        end else begin
            mode <= next_mode;
        end
    end

    // =====================================================
    // Registered mode outputs
    // =====================================================
    wire nxtActive;
    wire nxtSub;
    wire nxtStandby;
    wire nxtWatch;
    wire nxtOscOff;
    wire nxtCpuClk;

    assign nxtActive = (next_mode == pmc_pkg::PMC_ACT_HI) ||
                       (next_mode == pmc_pkg::PMC_ACT_MID) ||
                       (next_mode == pmc_pkg::PMC_SUBACT);
    assign nxtSub = (next_mode == pmc_pkg::PMC_SUBACT) ||
                    (next_mode == pmc_pkg::PMC_SUBSLEEP);
    assign nxtStandby = (next_mode == pmc_pkg::PMC_STANDBY);
    assign nxtWatch = (next_mode == pmc_pkg::PMC_WATCH);
    // Oscillator restarts as soon as the settling wait begins
    assign nxtOscOff = nxtSub || nxtStandby || nxtWatch;
    assign nxtCpuClk =
        (next_mode == pmc_pkg::PMC_ACT_HI) ? 1'b1 :
        (next_mode == pmc_pkg::PMC_ACT_MID) ? clkBus.midTick :
        (next_mode == pmc_pkg::PMC_SUBACT) ? clkBus.subTick : 1'b0;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            modeCode <= 4'h0;
            cpuRun <= 1'b1;
            cpuClkEn <= 1'b1;
            sysOscRun <= 1'b1;
            portHiZ <= 1'b0;
            extIrqHold <= 1'b0;
            timerARun <= 1'b1;
            watchSampleEn <= 1'b0;
        end else begin
            modeCode <= next_mode;
            cpuRun <= nxtActive;
            cpuClkEn <= nxtCpuClk;
            sysOscRun <= !nxtOscOff;
            portHiZ <= nxtStandby;
            extIrqHold <= nxtStandby || nxtWatch;
            timerARun <= nxtStandby ? 1'b0 :
                         (nxtSub || nxtWatch) ? timebaseWatchSelect :
                         1'b1;
            watchSampleEn <= clkBus.sampleTick;
        end
    end

endmodule // pmc_power_mode_control

`default_nettype wire

// ===== tb/pmc_power_mode_control_checker.sv
// Port checker for the power mode controller.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/10ps
`default_nettype none

module pmc_power_mode_control_checker #(
    parameter int SETTLE_4 = 131072
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] regAddr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic timebaseWatchSelect,
    input wire logic wakeIrq0,
    input wire logic wakeIrq1,
    input wire logic [3:0] modeCode,
    input wire logic cpuRun,
    input wire logic sysOscRun,
    input wire logic portHiZ,
    input wire logic extIrqHold,
    input wire logic timerARun
);
    // ==========================================
    // Settle length, too long for a repetition
    int settleCnt;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settleCnt <= 0;
        end else begin
            settleCnt <= (modeCode == 4'h8) ? settleCnt + 1 : 0;
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    fixed_one_a: assert property (
        $past(regRd) && $past(regAddr) == 16'hfff0 |-> regRdData[2])
        else $error("ctrl a bit 2 low");
    fixed_high_a: assert property (
        $past(regRd) && $past(regAddr) == 16'hfff1 |-> &regRdData[7:5])
        else $error("ctrl b top bits low");
    standby_float_a: assert property (
        modeCode == 4'h7 |-> portHiZ && !sysOscRun)
        else $error("standby outputs wrong");
    irq_hold_a: assert property (
        modeCode inside {4'h6, 4'h7} |-> extIrqHold)
        else $error("interrupts not held");
    timer_keep_a: assert property (
        modeCode inside {[4'h4:4'h6]} && $stable(timebaseWatchSelect)
        |-> timerARun == timebaseWatchSelect)
        else $error("timer run wrong");
    standby_stay_a: assert property (
        modeCode == 4'h7 && !wakeIrq0 && !wakeIrq1 |=> modeCode == 4'h7)
        else $error("standby left");
    standby_wake_a: assert property (
        modeCode == 4'h7 && wakeIrq0 |=> modeCode == 4'h8 && sysOscRun)
        else $error("no settle after wake");
    settle_bound_a: assert property (
        settleCnt <= SETTLE_4)
        else $error("settle too long");
    cpu_halt_a: assert property (
        modeCode inside {4'h2, 4'h3, [4'h5:4'h8]} |-> !cpuRun)
        else $error("cpu runs while halted");
    sleep_wake_a: assert property (
        modeCode == 4'h3 && wakeIrq0 |=> modeCode == 4'h1 && cpuRun)
        else $error("sleep wake speed wrong");

    cover property (modeCode == 4'h7 ##1 modeCode == 4'h8);
    cover property (modeCode == 4'h6 ##1 modeCode == 4'h4);
    cover property (modeCode == 4'h3 ##1 modeCode == 4'h1);
endmodule // pmc_power_mode_control_checker

bind pmc_power_mode_control pmc_power_mode_control_checker #(
    .SETTLE_4(SETTLE_4)
) i_pmc_power_mode_control_checker (
    .core_clk, .resetn, .regAddr, .regRd, .regRdData, .timebaseWatchSelect,
    .wakeIrq0, .wakeIrq1, .modeCode, .cpuRun, .sysOscRun, .portHiZ,
    .extIrqHold, .timerARun
);

`default_nettype wire

// ===== tb/pmc_cpu_model.sv
// CPU model: register bus master and sleep instruction pulses.
// Assumes the controller samples strobes on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module pmc_cpu_model (
    input wire logic core_clk,
    output logic [15:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [7:0] regRdData,
    output logic sleepExec
);
    initial begin
        {regAddr, regWrData, regWr, regRd, sleepExec} = '0;
    end

    // ==========================================
    // Bus cycles
    // Callers keep the software field limits.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic slp();
        @(posedge core_clk);
        sleepExec <= 1'b1;
        @(posedge core_clk);
        sleepExec <= 1'b0;
    endtask
endmodule // pmc_cpu_model

`default_nettype wire

// ===== tb/pmc_power_mode_control_tb.sv
// Self-checking bench for the power mode controller.
// Assumes 200 MHz core clock and settle counts cut to 8..128.
`timescale 1ns/10ps
`default_nettype none

module pmc_power_mode_control_tb;
    logic core_clk = 1'b0, resetn = 1'b0, regWr, regRd, sleepExec;
    logic tbSel = 1'b0, wakeIrq0 = 1'b0, cpuClkEn, watchSampleEn;
    logic cpuRun, sysOscRun, portHiZ, extIrqHold;
    logic [15:0] regAddr;
    logic [7:0] regWrData, regRdData, d;
    logic [5:0] wcnt = 6'h00;
    logic [3:0] modeCode;
    int fails, checkCount, cyc, n;
    // {ctrl a, ctrl b, time-base, mode after sleep, mode after wake}
    localparam logic [27:0] ROWS [7] = '{28'h07e0020, 28'h07e4031,
        28'h87e0070, 28'h87e0160, 28'h8fe0164, 28'h07ec011, 28'h8fe8144};

    pmc_cpu_model i_pmc_cpu_model (.core_clk, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .sleepExec);
    pmc_power_mode_control #(.SETTLE_0(8), .SETTLE_1(16), .SETTLE_2(32),
        .SETTLE_3(64), .SETTLE_4(128)) i_pmc_power_mode_control (
        .core_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .sleepExec, .timebaseWatchSelect(tbSel),
        .wakeTimerA(1'b0), .wakeIrq0, .wakeIrq1(1'b0), .wakeOther(1'b0),
        .watchClk(wcnt[5]), .modeCode, .cpuRun, .cpuClkEn, .sysOscRun,
        .portHiZ, .extIrqHold, .timerARun(), .watchSampleEn);

    // ==========================================
    // Clocks and helpers
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) wcnt <= wcnt + 6'h01;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic expm(input logic [3:0] m);
        for (int i = 0; i < 300 && modeCode !== m; i++) tick();
        chk({4'h0, modeCode}, {4'h0, m});
    endtask
    task automatic sleepTo(input logic [3:0] m);
        i_pmc_cpu_model.slp();
        #1;
        chk({4'h0, modeCode}, {4'h0, m});
        chk({4'h0, cpuRun, portHiZ, extIrqHold, sysOscRun},
            {4'h0, m inside {0, 1, 4}, m == 7, m inside {6, 7}, m < 4});
    endtask
    task automatic wake();
        @(posedge core_clk);
        wakeIrq0 <= 1'b1;
        @(posedge core_clk);
        wakeIrq0 <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        i_pmc_cpu_model.wr(a, v);
    endtask
    task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
        i_pmc_cpu_model.rd(a, d);
        chk(d, e);
    endtask
    function automatic logic pulse(input bit s);
        return s ? watchSampleEn : cpuClkEn;
    endfunction
    // Gap between two pulses, in core clock cycles
    task automatic gap(input bit s, input logic [7:0] e);
        #1;
        for (int i = 0; i < 300 && pulse(s) !== 1'b1; i++) tick();
        n = 0;
        do begin
            tick();
            n++;
        end while (n < 300 && pulse(s) !== 1'b1);
        chk(n[7:0], e);
    endtask
    task automatic rst();
        @(posedge core_clk);
        resetn <= 1'b0;
        tbSel <= 1'b0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        for (int r = 0; r < 7; r++) begin
            rst();
            tbSel <= ROWS[r][8];
            wr(16'hfff0, ROWS[r][27:20]);
            wr(16'hfff1, ROWS[r][19:12]);
            sleepTo(ROWS[r][7:4]);
            wake();
            expm(ROWS[r][3:0]);
            $display("row %0d done", r);
        end
        for (int c = 0; c < 5; c++) begin
            rst();
            wr(16'hfff0, {1'b1, c[2:0], 4'h7});
            sleepTo(4'h7);
            wake();
            expm(4'h8);
            for (n = 1; n < 300 && modeCode === 4'h8; n++) tick();
            chk(n[7:0] - 8'h01, 8'h08 << c);
            $display("settle code %0d done", c);
        end
        rst();
        rdChk(16'hfff0, 8'h07);
        rdChk(16'hfff1, 8'he0);
        wr(16'hfff0, 8'hff);
        wr(16'hfff1, 8'hff);
        rdChk(16'hfff0, 8'hff);
        rdChk(16'hfff1, 8'hff);
        wr(16'hfff0, 8'h00);
        wr(16'hfff1, 8'h00);
        rdChk(16'hfff0, 8'h04);
        rdChk(16'hfff1, 8'he0);
        rdChk(16'hfff2, 8'h00);
        gap(1'b1, 8'h10);
        wr(16'hfff1, 8'h10);
        gap(1'b1, 8'h04);
        $display("register test done");
        rst();
        tbSel <= 1'b1;
        wr(16'hfff0, 8'h8f);
        wr(16'hfff1, 8'hea);
        sleepTo(4'h4);
        wr(16'hfff1, 8'he9);
        rdChk(16'hfff1, 8'hea);
        gap(1'b0, 8'h80);
        wr(16'hfff1, 8'hee);
        wr(16'hfff0, 8'h87);
        sleepTo(4'h1);
        gap(1'b0, 8'h80);
        wr(16'hfff0, 8'h07);
        wr(16'hfff1, 8'he8);
        sleepTo(4'h0);
        $display("direct switch test done");
        summarize();
    end
endmodule // pmc_power_mode_control_tb

`default_nettype wire
